// *** core/scan_tap.sv ***
/*
  Boundary-scan test access port with boundary register, bypass,
  instruction decode, user scan hooks and configuration scan path.
  Assumes tck, tms, tdi and io pins arrive asynchronously and are
  sampled by clk, which runs much faster than tck.
*/
// Implementation choices: the address-and-strobe port and the register offsets.
// Function
// - three cells per io block, tdo bits partial
// - program, configuration_clock, done pins carry no cells
// - extest capture grabs every cell together
// - tdo tristate bit0, output bit1, update last
// - one-flop bypass between tdi and tdo
// - two user select outputs from decode
// - user instruction routes user scan-out to tdo
// - data register shift clock to user logic
// - nand of tck and run-test-idle out
// - three-bit instruction decode table
// - readback and configure through the scan path
// - per block: tristate, output, input order
// - tap pad outputs off, tap from pins
// - clock pads read pins, drivable by scan
// - non-clock use of clock pad overrides normally
// - pulls stay active; all up before config
// - chain order top, left, bottom, right edges
// - tap pins released after config unless kept
// - reset, update, shift state outputs to user
// - sixteen-state controller, ir, data registers
// - scan usable before config, after if kept
`timescale 1ns/1ps
`default_nettype none
module scan_tap (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // scan pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // configuration logic
  input wire logic config_done,
  input wire logic cfg_readback_data,
  input wire logic cfg_dout,
  output logic cfg_data,
  output logic cfg_shift,
  // io blocks: pins and core side
  input wire logic [tap_pkg::N_IOB-1:0] io_pin_in,
  input wire logic [tap_pkg::N_IOB-1:0] io_core_out,
  input wire logic [tap_pkg::N_IOB-1:0] io_core_oe,
  input wire logic [tap_pkg::N_IOB-1:0] clock_pad_is_clock,
  output logic [tap_pkg::N_IOB-1:0] io_core_in,
  output logic [tap_pkg::N_IOB-1:0] io_pin_out,
  output logic [tap_pkg::N_IOB-1:0] io_pin_oe,
  // user scan hooks
  input wire logic user_scan_out_first,
  input wire logic user_scan_out_second,
  output logic user_select_first,
  output logic user_select_second,
  output logic user_shift_clock,
  output logic idle_clock_gate,
  output logic user_reset,
  output logic user_update,
  output logic user_shift,
  output logic special_update_bit,
  // pad control
  output logic tap_pad_out_disable,
  output logic tap_pins_user,
  output logic pull_up_all,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  localparam int N = tap_pkg::N_IOB;
  localparam int L = tap_pkg::BSR_LEN;

  function automatic logic is_dr_bsr(input logic [2:0] ins);
    is_dr_bsr = (ins == tap_pkg::INS_EXTEST) ||
                (ins == tap_pkg::INS_SAMPLE);
  endfunction

  function automatic logic is_user(input logic [2:0] ins);
    is_user = (ins == tap_pkg::INS_FIRST_USER_INSTRUCTION) ||
              (ins == tap_pkg::INS_SECOND_USER_INSTRUCTION);
  endfunction

  // pin synchronisers
  logic [2:0] pin_m;
  logic [2:0] pin_s;
  logic tck_d;
  logic [N-1:0] io_m;
  logic [N-1:0] io_s;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_m <= 3'h0;
      pin_s <= 3'h0;
      tck_d <= 1'h0;
      io_m <= '0;
      io_s <= '0;
    end else begin
      pin_m <= {tck, tms, tdi};
      pin_s <= pin_m;
      tck_d <= pin_s[2];
      io_m <= io_pin_in;
      io_s <= io_m;
    end
  end

  // tap pins come straight from the pads, never from scan cells
  wire tck_s = pin_s[2];
  wire tms_s = pin_s[1];
  wire tdi_s = pin_s[0];
  wire tck_rise = tck_s & ~tck_d;
  wire tck_fall = ~tck_s & tck_d;

  // control register
  logic scan_keep;

  // scan alive before config, after it only when kept
  wire scan_active = ~config_done | scan_keep;

  // controller
  tap_pkg::tap_state_e state;
  tap_pkg::tap_state_e next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      tap_pkg::st_reset:
        next_state = tms_s ? tap_pkg::st_reset : tap_pkg::st_idle;
      tap_pkg::st_idle:
        next_state = tms_s ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
      tap_pkg::st_sel_dr:
        next_state = tms_s ? tap_pkg::st_sel_ir : tap_pkg::st_cap_dr;
      tap_pkg::st_cap_dr:
        next_state = tms_s ? tap_pkg::st_exit1_dr : tap_pkg::st_shift_dr;
      tap_pkg::st_shift_dr:
        next_state = tms_s ? tap_pkg::st_exit1_dr : tap_pkg::st_shift_dr;
      tap_pkg::st_exit1_dr:
        next_state = tms_s ? tap_pkg::st_upd_dr : tap_pkg::st_pause_dr;
      tap_pkg::st_pause_dr:
        next_state = tms_s ? tap_pkg::st_exit2_dr : tap_pkg::st_pause_dr;
      tap_pkg::st_exit2_dr:
        next_state = tms_s ? tap_pkg::st_upd_dr : tap_pkg::st_shift_dr;
      tap_pkg::st_upd_dr:
        next_state = tms_s ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
      tap_pkg::st_sel_ir:
        next_state = tms_s ? tap_pkg::st_reset : tap_pkg::st_cap_ir;
      tap_pkg::st_cap_ir:
        next_state = tms_s ? tap_pkg::st_exit1_ir : tap_pkg::st_shift_ir;
      tap_pkg::st_shift_ir:
        next_state = tms_s ? tap_pkg::st_exit1_ir : tap_pkg::st_shift_ir;
      tap_pkg::st_exit1_ir:
        next_state = tms_s ? tap_pkg::st_upd_ir : tap_pkg::st_pause_ir;
      tap_pkg::st_pause_ir:
        next_state = tms_s ? tap_pkg::st_exit2_ir : tap_pkg::st_pause_ir;
      tap_pkg::st_exit2_ir:
        next_state = tms_s ? tap_pkg::st_upd_ir : tap_pkg::st_shift_ir;
      tap_pkg::st_upd_ir:
        next_state = tms_s ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
    endcase
  end

  // a released tap is parked in reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= tap_pkg::st_reset;
    end else if (!scan_active) begin
      state <= tap_pkg::st_reset;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  wire in_cap_dr = state == tap_pkg::st_cap_dr;
  wire in_shift_dr = state == tap_pkg::st_shift_dr;
  wire in_shift_ir = state == tap_pkg::st_shift_ir;

  // instruction register
  logic [2:0] ir_sh;
  logic [2:0] ir;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_sh <= tap_pkg::IR_RESET;
      ir <= tap_pkg::IR_RESET;
    end else if (state == tap_pkg::st_reset) begin
      ir_sh <= tap_pkg::IR_RESET;
      ir <= tap_pkg::IR_RESET;
    end else begin
      if (tck_rise && state == tap_pkg::st_cap_ir)
        ir_sh <= tap_pkg::IR_CAPTURE;
      else if (tck_rise && in_shift_ir)
        ir_sh <= {tdi_s, ir_sh[2:1]};
      if (tck_fall && state == tap_pkg::st_upd_ir)
        ir <= ir_sh;
    end
  end

  // decode
  wire sel_extest = ir == tap_pkg::INS_EXTEST;
  wire sel_bsr = is_dr_bsr(ir);
  wire sel_first_user_instruction = ir == tap_pkg::INS_FIRST_USER_INSTRUCTION;
  wire sel_second_user_instruction = ir == tap_pkg::INS_SECOND_USER_INSTRUCTION;
  wire sel_rdbk = ir == tap_pkg::INS_READBACK;
  wire sel_cfg = ir == tap_pkg::INS_CONFIGURE;

  // boundary register; only io blocks, tdo bits and the update bit have cells,
  // the program, configuration_clock and done pins stay off the chain
  logic [L-1:0] bsr;
  logic [L-1:0] bsr_upd;
  logic [L-1:0] cap_vec;

  // io blocks are indexed along the ring: top edge right to left,
  // left edge down, bottom edge left to right, right edge up
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cell
      localparam int B = tap_pkg::IOB_BASE + tap_pkg::CELLS_PER_IOB * g;
      // tristate nearest tdo, then output, then input
      assign cap_vec[B + tap_pkg::CELL_TRI] = io_core_oe[g];
      assign cap_vec[B + tap_pkg::CELL_OUT] = io_core_out[g];
      assign cap_vec[B + tap_pkg::CELL_IN] = io_s[g];
      // clock pads in clock use feed the core from the pin only
      wire keep_pin = tap_pkg::CLK_PAD_MASK[g] & clock_pad_is_clock[g];
      wire drive_in = sel_extest & ~keep_pin;
      assign io_core_in[g] = drive_in ? bsr_upd[B + tap_pkg::CELL_IN]
                                      : io_s[g];
      // clock pads too may be driven from scan data here
      assign io_pin_out[g] = sel_extest ? bsr_upd[B + tap_pkg::CELL_OUT]
                                        : io_core_out[g];
      assign io_pin_oe[g] = sel_extest ? bsr_upd[B + tap_pkg::CELL_TRI]
                          : (sel_cfg ? 1'b0 : io_core_oe[g]);
    end
  endgenerate

  assign cap_vec[tap_pkg::BIT_TDO_T] = tdo_oe;
  assign cap_vec[tap_pkg::BIT_TDO_O] = tdo;
  assign cap_vec[tap_pkg::BIT_UPD] = bsr_upd[tap_pkg::BIT_UPD];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bsr <= '0;
      bsr_upd <= '0;
    end else begin
      if (tck_rise && in_cap_dr && sel_bsr)
        bsr <= cap_vec;
      else if (tck_rise && in_shift_dr && sel_bsr)
        bsr <= {tdi_s, bsr[L-1:1]};
      if (tck_fall && state == tap_pkg::st_upd_dr && sel_bsr)
        bsr_upd <= bsr;
    end
  end

  // bypass
  logic bypass;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bypass <= 1'h0;
    end else if (tck_rise && in_cap_dr) begin
      bypass <= 1'h0;
    end else if (tck_rise && in_shift_dr) begin
      bypass <= tdi_s;
    end
  end

  // tdo source
  logic dr_out;

  always_comb begin
    unique case (ir)
      tap_pkg::INS_EXTEST, tap_pkg::INS_SAMPLE:
        dr_out = bsr[0];
      tap_pkg::INS_FIRST_USER_INSTRUCTION:
        dr_out = user_scan_out_first;
      tap_pkg::INS_SECOND_USER_INSTRUCTION:
        dr_out = user_scan_out_second;
      tap_pkg::INS_READBACK:
        dr_out = cfg_readback_data;
      tap_pkg::INS_CONFIGURE:
        dr_out = cfg_dout;
      tap_pkg::INS_RESERVED, tap_pkg::INS_BYPASS:
        dr_out = bypass;
    endcase
  end

  // tdo changes on the falling tck edge, driven only while shifting
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tdo <= 1'h0;
      tdo_oe <= 1'h0;
    end else if (tck_fall) begin
      tdo <= in_shift_ir ? ir_sh[0] : dr_out;
      tdo_oe <= in_shift_dr | in_shift_ir;
    end
  end

  // configuration path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_data <= 1'h0;
      cfg_shift <= 1'h0;
    end else begin
      cfg_data <= tdi_s;
      cfg_shift <= tck_rise & in_shift_dr & (sel_cfg | sel_rdbk);
    end
  end

  // user hooks
  wire user_dr = in_cap_dr | in_shift_dr;
  wire user_any = is_user(ir);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      user_select_first <= 1'h0;
      user_select_second <= 1'h0;
      user_shift_clock <= 1'h0;
      idle_clock_gate <= 1'h1;
      user_reset <= 1'h0;
      user_update <= 1'h0;
      user_shift <= 1'h0;
    end else begin
      user_select_first <= sel_first_user_instruction;
      user_select_second <= sel_second_user_instruction;
      user_shift_clock <= tck_s & user_dr & user_any;
      idle_clock_gate <= ~(tck_s & (state == tap_pkg::st_idle));
      user_reset <= state == tap_pkg::st_reset;
      user_update <= state == tap_pkg::st_upd_dr;
      user_shift <= in_shift_dr;
    end
  end

  assign special_update_bit = bsr_upd[tap_pkg::BIT_UPD];

  // pad control; pulls are never switched off by scan
  assign tap_pad_out_disable = scan_active;
  assign tap_pins_user = ~scan_active;
  assign pull_up_all = ~config_done;

  // register port
  wire wr_ctrl = reg_wr && reg_addr == tap_pkg::REG_CTRL;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scan_keep <= tap_pkg::CTRL_KEEP_RESET;
    end else if (wr_ctrl) begin
      scan_keep <= reg_wdata[tap_pkg::CTRL_KEEP_BIT];
    end
  end

  logic [7:0] status;

  always_comb begin
    status = 8'h00;
    status[tap_pkg::STAT_STATE_LSB +: 4] = state;
    status[tap_pkg::STAT_IR_LSB +: 3] = ir;
    status[tap_pkg::STAT_ACTIVE_BIT] = scan_active;
  end

  wire [7:0] rd_mux =
    reg_addr == tap_pkg::REG_CTRL ? {7'h00, scan_keep} :
    reg_addr == tap_pkg::REG_STATUS ? status : 8'h00;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule
`default_nettype wire

// *** core/tap_pkg.sv ***
/*
  Constants for the boundary-scan test access logic: chain layout,
  instruction codes, reset values and the local register map.
  Assumes a single clock domain clk; the scan pins are sampled on it.
*/
package tap_pkg;

  // io blocks on the chain, in chain order from the tdo end
  localparam int N_IOB = 4;
  // which io blocks sit on a primary global clock pad
  localparam logic [N_IOB-1:0] CLK_PAD_MASK = 4'h9;

  // boundary register layout
  localparam int BIT_TDO_T = 0;
  localparam int BIT_TDO_O = 1;
  localparam int IOB_BASE = 2;
  localparam int CELLS_PER_IOB = 3;
  localparam int CELL_TRI = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_IN = 2;
  localparam int BSR_LEN = IOB_BASE + CELLS_PER_IOB * N_IOB + 1;
  localparam int BIT_UPD = BSR_LEN - 1;

  // instruction codes
  localparam int IR_LEN = 3;
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_SAMPLE = 3'h1;
  localparam logic [2:0] INS_FIRST_USER_INSTRUCTION = 3'h2;
  localparam logic [2:0] INS_SECOND_USER_INSTRUCTION = 3'h3;
  localparam logic [2:0] INS_READBACK = 3'h4;
  localparam logic [2:0] INS_CONFIGURE = 3'h5;
  localparam logic [2:0] INS_RESERVED = 3'h6;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic [2:0] IR_RESET = INS_BYPASS;

  // local registers
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_KEEP_BIT = 0;
  localparam logic CTRL_KEEP_RESET = 1'h0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_IR_LSB = 4;
  localparam int STAT_ACTIVE_BIT = 7;

  typedef enum logic [3:0] {
    st_reset, st_idle,
    st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr,
    st_pause_dr, st_exit2_dr, st_upd_dr,
    st_sel_ir, st_cap_ir, st_shift_ir, st_exit1_ir,
    st_pause_ir, st_exit2_ir, st_upd_ir
  } tap_state_e;

endpackage

// *** dv/jtag_tester.sv ***
/*
  Model of the external scan tester: drives tck, tms, tdi, samples tdo.
  Assumes the block's clk; tck toggles only inside frames.
*/
`timescale 1ns/1ps
`default_nettype none
module jtag_tester (
  // clock
  input wire logic clk,
  // scan pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one tck period of 8 clk, tdo taken at the rising edge
  task automatic pulse(input logic m, input logic d, output logic q);
    @(posedge clk);
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge clk);
    q = tdo;
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    tck <= 1'b0;
  endtask

  task automatic reset_tap();
    logic q;
    for (int i = 0; i < 6; i++) pulse(i < 5, 1'b0, q);
  endtask

  // from idle: capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    logic q;
    dout = 16'h0000;
    pulse(1'b1, 1'b0, q);
    if (ir) pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], q);
      dout[i] = q;
    end
    pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    tdi <= ~tdi;
  endtask
endmodule
`default_nettype wire

// *** dv/tap_properties.sv ***
/*
  Concurrent checks on the ports of the scan tap block.
  Assumes one clock domain clk with asynchronous active-low rst_b.
*/
`timescale 1ns/1ps
`default_nettype none
module tap_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // observed ports
  input wire logic config_done,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic user_select_first,
  input wire logic user_select_second,
  input wire logic user_shift_clock,
  input wire logic idle_clock_gate,
  input wire logic user_reset,
  input wire logic user_update,
  input wire logic user_shift,
  input wire logic cfg_shift,
  input wire logic pull_up_all,
  input wire logic tap_pad_out_disable,
  input wire logic tap_pins_user
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence scan_off;
    tap_pins_user [*4];
  endsequence
  sequence status_read;
    reg_rd && reg_addr == tap_pkg::REG_STATUS;
  endsequence

  held_reset_a: assert property (
    scan_off |-> user_reset && !user_select_first && !user_select_second)
    else $error("tap not held in reset while scan is off");
  pull_up_a: assert property (pull_up_all == !config_done)
    else $error("pull-up does not follow configuration state");
  pad_off_a: assert property (
    tap_pad_out_disable != tap_pins_user && (config_done || tap_pad_out_disable))
    else $error("tap pad disable and pin release disagree");
  select_excl_a: assert property (
    !(user_select_first && user_select_second))
    else $error("both user selects high");
  shift_clk_a: assert property (
    user_shift_clock |-> user_select_first || user_select_second)
    else $error("user shift clock outside a user instruction");
  state_excl_a: assert property (
    $onehot0({user_reset, user_update, user_shift}))
    else $error("several state outputs high");
  idle_gate_a: assert property (
    !idle_clock_gate |-> !user_reset && !user_update && !user_shift)
    else $error("idle gate low outside run-test-idle");
  cfg_pulse_a: assert property (cfg_shift |=> !cfg_shift [*5])
    else $error("configuration shift pulse too long or too close");
  rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  status_active_a: assert property (
    status_read |=> reg_rdata[7] == !$past(tap_pins_user))
    else $error("status active bit wrong");
endmodule
`default_nettype wire

bind scan_tap tap_properties u_tap_properties (.clk(clk), .rst_b(rst_b),
  .config_done(config_done), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .user_select_first(user_select_first),
  .user_select_second(user_select_second), .user_shift_clock(user_shift_clock),
  .idle_clock_gate(idle_clock_gate), .user_reset(user_reset),
  .user_update(user_update), .user_shift(user_shift), .cfg_shift(cfg_shift),
  .pull_up_all(pull_up_all), .tap_pad_out_disable(tap_pad_out_disable),
  .tap_pins_user(tap_pins_user));

// *** dv/tb_top.sv ***
/*
  Self-checking bench for the scan tap block.
  Assumes the tester model drives the scan pins; 40 MHz clk.
*/
`timescale 1ns/1ps
`default_nettype none
`define expect_eq(name, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("mismatch %s expected %h seen %h", name, exp, got); \
    end \
  end
module tb_top;
  logic clk, rst_b, config_done, cfg_readback_data, cfg_dout, reg_wr, reg_rd;
  logic user_scan_out_first, user_scan_out_second, tck, tms, tdi, tdo, tdo_oe, cfg_data;
  logic [3:0] io_pin_in, io_core_out, io_core_oe, clock_pad_is_clock, reg_addr;
  logic [3:0] io_core_in, io_pin_out, io_pin_oe;
  logic [7:0] reg_wdata, reg_rdata, rd;
  logic user_select_first, user_select_second, idle_clock_gate;
  logic tap_pins_user, pull_up_all, tap_pad_out_disable, special_update_bit;
  logic [15:0] q;
  logic [15:0] pat = 16'h60C0;
  logic [3:0] dr_exp [8] = '{4'h0, 4'h0, 4'hF, 4'h0, 4'hF, 4'h0, 4'h4, 4'h4};
  int errors, compares;

  scan_tap u_scan_tap (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .config_done(config_done),
    .cfg_readback_data(cfg_readback_data), .cfg_dout(cfg_dout), .cfg_data(cfg_data),
    .cfg_shift(), .io_pin_in(io_pin_in), .io_core_out(io_core_out),
    .io_core_oe(io_core_oe), .clock_pad_is_clock(clock_pad_is_clock),
    .io_core_in(io_core_in), .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe),
    .user_scan_out_first(user_scan_out_first),
    .user_scan_out_second(user_scan_out_second),
    .user_select_first(user_select_first),
    .user_select_second(user_select_second), .user_shift_clock(),
    .idle_clock_gate(idle_clock_gate), .user_reset(), .user_update(),
    .user_shift(), .special_update_bit(special_update_bit),
    .tap_pad_out_disable(tap_pad_out_disable), .tap_pins_user(tap_pins_user),
    .pull_up_all(pull_up_all), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  jtag_tester u_jtag_tester (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo));

  always #12.5 clk = ~clk;

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  task automatic test_done();
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // nearly five times the expected run of some 1700 clk
  initial begin
    #200_000;
    errors++;
    test_done();
  end

  initial begin
    {clk, rst_b, config_done, reg_wr, reg_rd, cfg_dout} = 6'h00;
    {cfg_readback_data, user_scan_out_first, user_scan_out_second} = 3'h6;
    {io_pin_in, io_core_out, io_core_oe, clock_pad_is_clock} = 16'h5AF8;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    `expect_eq("pull up", 1'b1, pull_up_all)
    `expect_eq("tap pads off", 1'b1, tap_pad_out_disable)
    `expect_eq("idle gate", 1'b1, idle_clock_gate)
    reg_read(tap_pkg::REG_STATUS, rd);
    `expect_eq("status", 8'hF0, rd)
    u_jtag_tester.reset_tap();
    u_jtag_tester.scan(1'b1, 3, 16'(tap_pkg::INS_SAMPLE), q);
    `expect_eq("ir capture", tap_pkg::IR_CAPTURE, q[2:0])
    `expect_eq("tdo idle", 1'b0, tdo_oe)
    for (int c = 0; c < 8; c++) begin
      u_jtag_tester.scan(1'b1, 3, 16'(c), q);
      reg_read(tap_pkg::REG_STATUS, rd);
      `expect_eq("ir", c[2:0], rd[6:4])
      `expect_eq("select first", c == 2, user_select_first)
      `expect_eq("select second", c == 3, user_select_second)
      if (c == 5) `expect_eq("config oe", 4'h0, io_pin_oe)
      if (c > 0 && c < 5) `expect_eq("normal pins", io_core_out, io_pin_out)
      u_jtag_tester.scan(1'b0, 4, 16'h000A, q);
      if (c > 1) `expect_eq("dr out", dr_exp[c], q[3:0])
    end
    u_jtag_tester.scan(1'b1, 3, 16'(tap_pkg::INS_EXTEST), q);
    u_jtag_tester.scan(1'b0, tap_pkg::BSR_LEN, pat, q);
    `expect_eq("update bit", pat[tap_pkg::BIT_UPD], special_update_bit)
    `expect_eq("pin out 1", pat[6], io_pin_out[1])
    `expect_eq("pin out 2", pat[9], io_pin_out[2])
    for (int g = 0; g < 4; g++) begin
      `expect_eq("core in", g == 3 ? io_pin_in[g] : pat[4 + 3 * g], io_core_in[g])
    end
    u_jtag_tester.scan(1'b0, tap_pkg::BSR_LEN, 16'h0000, q);
    for (int g = 0; g < 4; g++) begin
      `expect_eq("in cell", io_pin_in[g], q[4 + 3 * g])
    end
    `expect_eq("pin in 3", io_pin_in[3], io_core_in[3])
    reg_write(tap_pkg::REG_CTRL, 8'h01);
    reg_read(tap_pkg::REG_CTRL, rd);
    `expect_eq("ctrl", 8'h01, rd)
    reg_read(4'hC, rd);
    `expect_eq("unmapped", 8'h00, rd)
    reg_write(tap_pkg::REG_STATUS, 8'h00);
    reg_read(tap_pkg::REG_STATUS, rd);
    `expect_eq("status ro", 8'h81, rd)
    config_done <= 1'b1;
    repeat (2) @(posedge clk);
    `expect_eq("pull off", 1'b0, pull_up_all)
    `expect_eq("kept", 1'b0, tap_pins_user)
    reg_write(tap_pkg::REG_CTRL, 8'h00);
    repeat (4) @(posedge clk);
    `expect_eq("released", 1'b1, tap_pins_user)
    reg_read(tap_pkg::REG_STATUS, rd);
    `expect_eq("status off", 8'h70, rd)
    `expect_eq("cfg data", tdi, cfg_data)
    test_done();
  end
endmodule
`default_nettype wire
